// ---- gpio_pkg.sv ----
// gpio_pkg: register map, reset values and bus codes for the two-port gpio block
// assumes an AHB-Lite slave with 32-bit data, one register per aligned word
package gpio_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int PORT_W = 8;
  localparam int IDX_W = 3;
  localparam int IDX_LSB = 2;
  localparam int MAP_W = 5;

  // ----------------------------------------------------------------
  // register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_A_PINS = 3'h0;
  localparam logic [IDX_W-1:0] IDX_A_DIR = 3'h1;
  localparam logic [IDX_W-1:0] IDX_A_LATCH = 3'h2;
  localparam logic [IDX_W-1:0] IDX_A_ANSEL = 3'h3;
  localparam logic [IDX_W-1:0] IDX_B_PINS = 3'h4;
  localparam logic [IDX_W-1:0] IDX_B_DIR = 3'h5;
  localparam logic [IDX_W-1:0] IDX_B_LATCH = 3'h6;
  localparam logic [IDX_W-1:0] IDX_B_ANSEL = 3'h7;

  // ----------------------------------------------------------------
  // field masks and reset values
  // ----------------------------------------------------------------
  localparam logic [PORT_W-1:0] ANSEL_A_MASK = 8'h2F;
  localparam logic [PORT_W-1:0] ANSEL_B_MASK = 8'h3F;
  localparam logic [PORT_W-1:0] DIR_RESET = 8'hFF;
  localparam logic [PORT_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [PORT_W-1:0] BYTE_ONES = 8'hFF;
  localparam int CLK_PIN_BIT = 6;

  // ----------------------------------------------------------------
  // AHB-Lite codes
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic [1:0] LANE_ZERO = 2'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage : gpio_pkg

// ---- gpio_sync2.sv ----
// gpio_sync2: two-flop synchroniser for a group of pin inputs
// assumes the pins are asynchronous to ref_clk
`timescale 1ns/10ps
module gpio_sync2 #(
  parameter int W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  import gpio_pkg::*;

  logic [W-1:0] stage1_r;

  // first stage feeds only the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= '0;
      syncOut <= '0;
    end else begin
      stage1_r <= asyncIn;
      syncOut <= stage1_r;
    end
  end

endmodule : gpio_sync2

// ---- gpio_port_lane.sv ----
// gpio_port_lane: direction, output latch and analog select of one 8-bit port
// assumes write strobes come one cycle after the bus address phase
`timescale 1ns/10ps
module gpio_port_lane #(
  parameter logic [7:0] ANSEL_MASK = 8'hFF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic wrPins,
  input wire logic wrDir,
  input wire logic wrLatch,
  input wire logic wrAnsel,
  input wire logic laneEn,
  input wire logic [gpio_pkg::PORT_W-1:0] wrData,
  input wire logic [gpio_pkg::PORT_W-1:0] pinRead,
  output logic [gpio_pkg::PORT_W-1:0] dir,
  output logic [gpio_pkg::PORT_W-1:0] latch,
  output logic [gpio_pkg::PORT_W-1:0] ansel
);
  import gpio_pkg::*;

  logic [PORT_W-1:0] wrMask;
  logic [PORT_W-1:0] modified;

  assign wrMask = laneEn ? BYTE_ONES : BYTE_ZERO;
  // RULE8 pins sampled, then modified
  assign modified = (pinRead & ~wrMask) | (wrData & wrMask);

  // RULE18 directions reset to input
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir <= DIR_RESET;
    end else if (wrDir) begin
      dir <= (dir & ~wrMask) | (wrData & wrMask);
    end
  end

  // RULE18 latch keeps contents over reset
  // RULE6 pin write lands in latch
  always_ff @(posedge ref_clk) begin
    if (wrPins || wrLatch) begin
      latch <= modified;
    end
  end

  // RULE15 analog mode after reset
  // RULE13 unimplemented bits stay zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ansel <= ANSEL_MASK;
    end else if (wrAnsel) begin
      ansel <= ((ansel & ~wrMask) | (wrData & wrMask)) & ANSEL_MASK;
    end
  end

endmodule : gpio_port_lane

// ---- gpio_port_a_b.sv ----
// gpio_port_a_b: two 8-bit bidirectional ports behind an AHB-Lite slave
// assumes pins are asynchronous, peripheral outputs are on ref_clk,
// and the pad resolves each pin from its out and output enable.
//
// Notes on behaviour
// RULE1 - several enabled outputs on one pin: only the highest priority drives.
// RULE2 - port A bit 6: clock output, then oscillator output, then latch.
// RULE3 - analog-selected pins still driven by digital outputs in same priority.
// RULE4 - analog select bit set connects analog input functions to the pin.
// RULE5 - pin levels register read returns live pin levels, one per bit.
// RULE6 - pin levels register write updates only the output latch.
// RULE7 - direction 1 turns driver off; 0 drives latch value onto pin.
// RULE8 - port writes are read-modify-write: pins sampled, modified, stored.
// RULE9 - direction bits control drivers even on analog-selected pins.
// RULE10 - software keeps direction at input on analog input pins.
// RULE11 - digital read of analog-selected pin returns zero.
// RULE12 - analog select 1 disables digital input; 0 gives digital use.
// RULE13 - port A analog select holds bits 5, 3..0; others read zero.
// RULE14 - analog select never affects digital output drive.
// RULE15 - analog select bits reset to analog; software clears them.
// RULE16 - port B behaves as port A for direction, latch, reads, masking.
// RULE17 - latch register read returns latch contents, not pin levels.
// RULE18 - directions reset to input; latch contents are not reset.
`timescale 1ns/10ps
module gpio_port_a_b (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic clkOutEn,
  input wire logic clkOutVal,
  input wire logic oscOutEn,
  input wire logic oscOutVal,
  input wire logic [gpio_pkg::PORT_W-1:0] portAIn,
  output logic [gpio_pkg::PORT_W-1:0] portAOut,
  output logic [gpio_pkg::PORT_W-1:0] portAOe,
  output logic [gpio_pkg::PORT_W-1:0] portAAnalogConn,
  input wire logic [gpio_pkg::PORT_W-1:0] portBIn,
  output logic [gpio_pkg::PORT_W-1:0] portBOut,
  output logic [gpio_pkg::PORT_W-1:0] portBOe,
  output logic [gpio_pkg::PORT_W-1:0] portBAnalogConn
);
  import gpio_pkg::*;

  // ----------------------------------------------------------------
  // bus address phase
  // ----------------------------------------------------------------
  logic addrValid;
  logic addrMapped;
  logic [IDX_W-1:0] addrIdx;
  logic wrPend_r;
  logic [IDX_W-1:0] wrIdx_r;
  logic wrLane_r;

  assign addrValid = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addrMapped = (haddr[31:MAP_W] == WORD_ZERO[31:MAP_W]);
  assign addrIdx = haddr[IDX_LSB +: IDX_W];

  // unmapped writes are dropped, still answered OKAY
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_r <= 1'b0;
      wrIdx_r <= IDX_A_PINS;
      wrLane_r <= 1'b0;
    end else begin
      wrPend_r <= addrValid && hwrite && addrMapped;
      wrIdx_r <= addrIdx;
      // byte lane 0 carries the register for any size at offset 0
      wrLane_r <= (haddr[1:0] == LANE_ZERO) || (hsize == 3'h2) || (hsize == 3'h1 && !haddr[1]);
    end
  end

  // zero wait states, always OKAY
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end

  // ----------------------------------------------------------------
  // pin inputs
  // ----------------------------------------------------------------
  logic [PORT_W-1:0] syncA;
  logic [PORT_W-1:0] syncB;
  logic [PORT_W-1:0] pinReadA;
  logic [PORT_W-1:0] pinReadB;
  logic [PORT_W-1:0] dirA;
  logic [PORT_W-1:0] latchA;
  logic [PORT_W-1:0] a_analog_bit;
  logic [PORT_W-1:0] dirB;
  logic [PORT_W-1:0] latchB;
  logic [PORT_W-1:0] ansB;

  gpio_sync2 #(.W(PORT_W)) u_sync_a (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn(portAIn),
    .syncOut(syncA)
  );

  gpio_sync2 #(.W(PORT_W)) u_sync_b (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .asyncIn(portBIn),
    .syncOut(syncB)
  );

  // RULE11 analog pins read as zero
  // RULE12 digital input buffer off
  assign pinReadA = syncA & ~a_analog_bit;
  assign pinReadB = syncB & ~ansB;

  // ----------------------------------------------------------------
  // register lanes
  // ----------------------------------------------------------------
  gpio_port_lane #(.ANSEL_MASK(ANSEL_A_MASK)) u_lane_a (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wrPins(wrPend_r && wrIdx_r == IDX_A_PINS),
    .wrDir(wrPend_r && wrIdx_r == IDX_A_DIR),
    .wrLatch(wrPend_r && wrIdx_r == IDX_A_LATCH),
    .wrAnsel(wrPend_r && wrIdx_r == IDX_A_ANSEL),
    .laneEn(wrLane_r),
    .wrData(hwdata[PORT_W-1:0]),
    .pinRead(pinReadA),
    .dir(dirA),
    .latch(latchA),
    .ansel(a_analog_bit)
  );

  // RULE16 port B uses the same lane
  gpio_port_lane #(.ANSEL_MASK(ANSEL_B_MASK)) u_lane_b (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .wrPins(wrPend_r && wrIdx_r == IDX_B_PINS),
    .wrDir(wrPend_r && wrIdx_r == IDX_B_DIR),
    .wrLatch(wrPend_r && wrIdx_r == IDX_B_LATCH),
    .wrAnsel(wrPend_r && wrIdx_r == IDX_B_ANSEL),
    .laneEn(wrLane_r),
    .wrData(hwdata[PORT_W-1:0]),
    .pinRead(pinReadB),
    .dir(dirB),
    .latch(latchB),
    .ansel(ansB)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [PORT_W-1:0] rdByte;

  always_comb begin
    rdByte = BYTE_ZERO;
    unique case (addrIdx)
      // RULE5 live pin levels
      IDX_A_PINS: rdByte = pinReadA;
      IDX_A_DIR: rdByte = dirA;
      // RULE17 latch contents
      IDX_A_LATCH: rdByte = latchA;
      IDX_A_ANSEL: rdByte = a_analog_bit;
      IDX_B_PINS: rdByte = pinReadB;
      IDX_B_DIR: rdByte = dirB;
      IDX_B_LATCH: rdByte = latchB;
      IDX_B_ANSEL: rdByte = ansB;
    endcase
  end

  // sampled in the address phase so data stands through the data phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= WORD_ZERO;
    end else if (addrValid && !hwrite) begin
      hrdata <= addrMapped ? {WORD_ZERO[31:PORT_W], rdByte} : WORD_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  logic [PORT_W-1:0] aOeNxt;
  logic [PORT_W-1:0] aValNxt;

  always_comb begin
    // RULE7 direction 0 drives latch
    // RULE9 analog select not consulted
    // RULE14 outputs ignore analog select
    aOeNxt = ~dirA;
    aValNxt = latchA;
    // RULE1 highest priority owns the pin
    // RULE2 clock out, oscillator, latch
    // RULE3 same order in analog mode
    if (clkOutEn) begin
      aOeNxt[CLK_PIN_BIT] = 1'b1;
      aValNxt[CLK_PIN_BIT] = clkOutVal;
    end else if (oscOutEn) begin
      aOeNxt[CLK_PIN_BIT] = 1'b1;
      aValNxt[CLK_PIN_BIT] = oscOutVal;
    end
  end

  // undriven bits show 0, which hides the unreset latch
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      portAOe <= BYTE_ZERO;
      portAOut <= BYTE_ZERO;
      portBOe <= BYTE_ZERO;
      portBOut <= BYTE_ZERO;
    end else begin
      portAOe <= aOeNxt;
      portAOut <= aValNxt & aOeNxt;
      // RULE16 port B latch only
      portBOe <= ~dirB;
      portBOut <= latchB & ~dirB;
    end
  end

  // RULE4 analog functions follow select
  // select resets to analog, so the connection does too
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      portAAnalogConn <= ANSEL_A_MASK;
      portBAnalogConn <= ANSEL_B_MASK;
    end else begin
      portAAnalogConn <= a_analog_bit;
      portBAnalogConn <= ansB;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  localparam logic [PORT_W-1:0] NOT_CLK_BIT = 8'hBF;

  // enables may stand across reset; the release edge still shows reset outputs
  a_clk_out_wins: assert property ( // RULE2
    rst_n && clkOutEn |=> portAOe[CLK_PIN_BIT] && portAOut[CLK_PIN_BIT] == $past(clkOutVal))
    else $error("clock output did not own port A bit 6");

  a_osc_out_second: assert property ( // RULE1
    rst_n && !clkOutEn && oscOutEn
    |=> portAOe[CLK_PIN_BIT] && portAOut[CLK_PIN_BIT] == $past(oscOutVal))
    else $error("oscillator output did not own port A bit 6");

  a_dir_sets_drive: assert property ( // RULE7
    ##1 (portAOe & NOT_CLK_BIT) == (~$past(dirA) & NOT_CLK_BIT))
    else $error("port A drivers do not follow direction");

  a_analog_still_drives: assert property ( // RULE14
    a_analog_bit[0] && !dirA[0] |=> portAOe[0] && portAOut[0] == $past(latchA[0]))
    else $error("analog select stopped a digital output");

  a_ansel_unimpl_zero: assert property ( // RULE13
    (a_analog_bit & ~ANSEL_A_MASK) == BYTE_ZERO)
    else $error("unimplemented analog select bit set");

  a_pin_write_latch: assert property ( // RULE6
    wrPend_r && wrIdx_r == IDX_A_PINS && wrLane_r |=> latchA == $past(hwdata[PORT_W-1:0]))
    else $error("pin register write missed the latch");

  a_pin_read_live: assert property ( // RULE5
    addrValid && !hwrite && addrMapped && addrIdx == IDX_A_PINS
    |=> hrdata[PORT_W-1:0] == ($past(syncA) & ~$past(a_analog_bit)))
    else $error("pin read did not return pin levels");

  a_analog_read_zero: assert property ( // RULE11
    addrValid && !hwrite && addrMapped && addrIdx == IDX_B_PINS
    |=> (hrdata[PORT_W-1:0] & $past(ansB)) == BYTE_ZERO)
    else $error("analog pin read not zero");

  a_latch_read_back: assert property ( // RULE17
    addrValid && !hwrite && addrMapped && addrIdx == IDX_A_LATCH
    |=> hrdata[PORT_W-1:0] == $past(latchA))
    else $error("latch read did not return latch");

  a_analog_connect: assert property ( // RULE4
    ##1 portBAnalogConn == $past(ansB))
    else $error("analog connection does not follow select");

  a_port_b_drive: assert property ( // RULE16
    ##1 portBOe == ~$past(dirB))
    else $error("port B drivers do not follow direction");

  c_clk_out_pin: cover property (clkOutEn && oscOutEn ##1 portAOe[CLK_PIN_BIT]);
  c_pin_write: cover property (wrPend_r && wrIdx_r == IDX_A_PINS);
  c_analog_driven: cover property (a_analog_bit[0] && portAOe[0]);
  c_osc_out_pin: cover property (!clkOutEn && oscOutEn ##1 portAOe[CLK_PIN_BIT]);
  c_analog_read: cover property (addrValid && !hwrite && addrIdx == IDX_B_PINS && ansB != BYTE_ZERO);

endmodule : gpio_port_a_b

// ---- gpio_pin_env.sv ----
// gpio_pin_env: pads of one port and the outside circuit that faces them
// assumes out is already 0 where oe is low; ext is an outside driver
`timescale 1ns/10ps
module gpio_pin_env (
  input wire logic [gpio_pkg::PORT_W-1:0] out,
  input wire logic [gpio_pkg::PORT_W-1:0] oe,
  input wire logic [gpio_pkg::PORT_W-1:0] ext,
  output logic [gpio_pkg::PORT_W-1:0] pin
);
  import gpio_pkg::*;
  // ------
  // pad resolution
  // ------
  // an enabled driver wins; the outside circuit only sets undriven pins
  assign pin = (oe & out) | (~oe & ext);
endmodule : gpio_pin_env

// ---- test_gpio_port_a_b.sv ----
// test_gpio_port_a_b: self-checking bench for the two-port gpio block
// assumes a zero-wait AHB-Lite slave and pads modelled by gpio_pin_env
`timescale 1ns/10ps
module test_gpio_port_a_b;
  import gpio_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = WORD_ZERO;
  logic [1:0] htrans = HTRANS_IDLE;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = WORD_ZERO;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic clkOutEn = 1'b0;
  logic clkOutVal = 1'b0;
  logic oscOutEn = 1'b0;
  logic oscOutVal = 1'b0;
  logic [PORT_W-1:0] portAIn, portAOut, portAOe, portAAnalogConn;
  logic [PORT_W-1:0] portBIn, portBOut, portBOe, portBAnalogConn;
  logic [PORT_W-1:0] ext [2];
  logic [PORT_W-1:0] mDir [2];
  logic [PORT_W-1:0] mLat [2];
  logic [PORT_W-1:0] mAns [2];
  int n_errors = 0;
  int n_tests = 0;

  assign hready = hreadyout;
  always #5 ref_clk = ~ref_clk;

  gpio_port_a_b gpio_port_a_b_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .clkOutEn(clkOutEn), .clkOutVal(clkOutVal), .oscOutEn(oscOutEn),
    .oscOutVal(oscOutVal), .portAIn(portAIn), .portAOut(portAOut), .portAOe(portAOe),
    .portAAnalogConn(portAAnalogConn), .portBIn(portBIn), .portBOut(portBOut),
    .portBOe(portBOe), .portBAnalogConn(portBAnalogConn)
  );
  gpio_pin_env pinEnvA (.out(portAOut), .oe(portAOe), .ext(ext[0]), .pin(portAIn));
  gpio_pin_env pinEnvB (.out(portBOut), .oe(portBOe), .ext(ext[1]), .pin(portBIn));

  // ------
  // checking and verdict
  // ------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: saw %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic finish_test;
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // ------
  // bus master
  // ------
  // entered just after a rising edge; holds each phase until hready
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    r = hrdata;
    chk(32'(hresp), 32'(HRESP_OKAY)); // accepted OKAY
  endtask : xfer

  function automatic logic [31:0] adr(input int i);
    return 32'(i) << IDX_LSB;
  endfunction : adr

  task automatic wr(input int i, input logic [31:0] d);
    logic [31:0] r;
    xfer(adr(i), 1'b1, d, r);
  endtask : wr

  task automatic rdc(input int i, input logic [31:0] e);
    logic [31:0] r;
    xfer(adr(i), 1'b0, WORD_ZERO, r);
    chk(r, e);
  endtask : rdc

  // ------
  // reference model of the pin drive
  // ------
  function automatic logic [PORT_W-1:0] expOe(input int p);
    logic [PORT_W-1:0] v;
    v = ~mDir[p];
    if (p == 0 && (clkOutEn || oscOutEn)) v[CLK_PIN_BIT] = 1'b1;
    return v;
  endfunction : expOe

  function automatic logic [PORT_W-1:0] expOut(input int p);
    logic [PORT_W-1:0] v;
    v = mLat[p] & ~mDir[p];
    if (p == 0 && clkOutEn) v[CLK_PIN_BIT] = clkOutVal;
    else if (p == 0 && oscOutEn) v[CLK_PIN_BIT] = oscOutVal;
    return v;
  endfunction : expOut

  // ------
  // watchdog
  // ------
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    finish_test();
  end

  // ------
  // main sequence
  // ------
  initial begin
    int p;
    int base;
    logic [31:0] d, a, l, r;
    logic [PORT_W-1:0] m, oe, lv;
    void'($urandom(32'h0000_0b5c));
    ext[0] = BYTE_ZERO;
    ext[1] = BYTE_ZERO;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk(32'(portAOe | portBOe), WORD_ZERO); // drivers off
    rdc(IDX_A_DIR, 32'(DIR_RESET)); // inputs
    rdc(IDX_B_DIR, 32'(DIR_RESET)); // same reset
    rdc(IDX_A_ANSEL, 32'(ANSEL_A_MASK)); // analog reset
    rdc(IDX_B_ANSEL, 32'(ANSEL_B_MASK)); // analog reset
    for (int k = 0; k < 40; k++) begin
      p = k % 2;
      base = p * 4;
      m = (p == 1) ? ANSEL_B_MASK : ANSEL_A_MASK;
      d = $urandom;
      a = $urandom;
      l = $urandom;
      if (k % 4 < 2) d = d | 32'(a[7:0] & m);
      ext[p] <= 8'($urandom);
      {clkOutEn, clkOutVal, oscOutEn, oscOutVal} <= 4'($urandom);
      // latch first, so a driven pin never shows an unwritten latch
      wr(base + (((k / 4) % 2 == 0) ? 2 : 0), l);
      wr(base + 1, d);
      wr(base + 3, a);
      mDir[p] = d[7:0];
      mAns[p] = a[7:0] & m;
      mLat[p] = l[7:0];
      repeat (4) @(posedge ref_clk);
      oe = expOe(p);
      lv = (oe & expOut(p)) | (~oe & ext[p]);
      chk(32'(p ? portBOe : portAOe), 32'(oe)); // drivers
      chk(32'(p ? portBOut : portAOut), 32'(expOut(p))); // pin six order
      chk(32'(p ? portBAnalogConn : portAAnalogConn), 32'(mAns[p])); // analog
      rdc(base, 32'(lv & ~mAns[p])); // live pins
      rdc(base + 2, 32'(mLat[p])); // latch read
      rdc(base + 3, 32'(mAns[p])); // masked bits
      rdc(base + 1, 32'(mDir[p])); // direction
    end
    xfer(32'h0000_0024, 1'b1, 32'(~mDir[0]), r);
    rdc(IDX_A_DIR, 32'(mDir[0])); // unmapped write dropped
    xfer(32'h0000_0020, 1'b0, WORD_ZERO, r);
    chk(r, WORD_ZERO); // unmapped read zero
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk(32'(portBOe), WORD_ZERO); // drivers off
    rdc(IDX_A_LATCH, 32'(mLat[0])); // latch kept
    rdc(IDX_B_LATCH, 32'(mLat[1])); // latch kept
    rdc(IDX_A_DIR, 32'(DIR_RESET)); // inputs
    rdc(IDX_B_ANSEL, 32'(ANSEL_B_MASK)); // analog reset
    finish_test();
  end
endmodule : test_gpio_port_a_b
